// ===== common/rss_pkg.sv
package rss_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int BOD_MIN_NS = 2000;
    localparam int BOD_MIN_CYC = (BOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOD_CNT_W = $clog2(BOD_MIN_CYC + 1);
    localparam int STARTUP_BASE_CYC = 4096;
    localparam int TOUT_CNT_W = 24;

    // register map
    localparam int REG_ADDR_W = 4;
    localparam logic [REG_ADDR_W-1:0] RESET_CAUSE_OFS = 4'h0;
    localparam logic [7:0] RESET_CAUSE_RST = 8'h00;
    localparam int WATCHDOG_FLAG_BIT = 3;
    localparam int BROWNOUT_FLAG_BIT = 2;
    localparam int PIN_FLAG_BIT = 1;
    localparam int POWERON_FLAG_BIT = 0;
    localparam logic [3:0] FLAG_MASK = 4'hf;

    // sleep mode select encodings
    typedef enum logic [2:0] {
        SLP_IDLE = 3'h0,
        SLP_ADC_NR = 3'h1,
        SLP_POWER_DOWN = 3'h2,
        SLP_POWER_SAVE = 3'h3,
        SLP_RSVD4 = 3'h4,
        SLP_RSVD5 = 3'h5,
        SLP_STANDBY = 3'h6,
        SLP_RSVD7 = 3'h7
    } rss_sleep_mode_t;

    // fuse settings, 1 = programmed
    typedef struct packed {
        logic brownout_enable_fuse;
        logic brownout_level_fuse;
        logic [3:0] clock_select_fuses;
    } rss_fuse_t;

    // power-management request group
    typedef struct packed {
        logic sleep_active;
        rss_sleep_mode_t sleep_mode;
        logic acmp_enable;
        logic acmp_use_ref;
        logic adc_enable;
        logic adc_conv_start;
    } rss_pm_req_t;

endpackage : rss_pkg

// ===== verification/rss_partner.sv
module rss_partner (
    input wire logic clk_i,
    input wire logic por_cmd_i,
    input wire logic pin_cmd_i,
    input wire logic wdt_cmd_i,
    input wire logic bod_cmd_i,
    // supply starts below the power-on level, pin released
    output logic por_active_o = 1'b1,
    output logic ext_rst_n_o = 1'b1,
    output logic wdt_expire_o = 1'b0,
    output logic bod_low_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // monitors follow their commands one edge late
    always @(posedge clk_i) begin
        por_active_o <= por_cmd_i;
        ext_rst_n_o <= pin_cmd_i;
        wdt_expire_o <= wdt_cmd_i;
        bod_low_o <= bod_cmd_i;
    end
endmodule // rss_partner

// ===== verification/testbench.sv
module testbench;
    import rss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BASE = 8;
    localparam logic [3:0] CS = 4'h1;
    // one edge in the monitor, one to enter the count, then the time-out
    localparam int REL = BASE * 2 + 2;
    logic clk, rst_n, wdt_en, wr, rd, io_n, core_n, vec, thr, bod_act, wdt_act;
    logic acmp_on, ref_on, adc_on, adc_ext, por, pin_n, wdt_exp, bod_low;
    logic por_cmd, pin_cmd, wdt_cmd, bod_cmd, deep;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [22:0] wake, ibuf;
    rss_fuse_t fuses;
    rss_pm_req_t pm;
    int errors, checked, n;
    rss_partner u_mon (.clk_i(clk), .por_cmd_i(por_cmd), .pin_cmd_i(pin_cmd),
        .wdt_cmd_i(wdt_cmd), .bod_cmd_i(bod_cmd), .por_active_o(por),
        .ext_rst_n_o(pin_n), .wdt_expire_o(wdt_exp), .bod_low_o(bod_low));
    rss_top #(.STARTUP_BASE_CYCLES(BASE)) u_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
        .FUSES_I(fuses), .POR_ACTIVE_I(por), .EXT_RST_N_I(pin_n), .WDT_ENABLE_I(wdt_en),
        .WDT_EXPIRE_I(wdt_exp), .BOD_LOW_I(bod_low), .PM_REQ_I(pm), .WAKE_PIN_MASK_I(wake),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .IO_RESET_N_O(io_n), .CORE_RESET_N_O(core_n),
        .VECTOR_FETCH_O(vec), .BOD_THRESH_SEL_O(thr), .BOD_ACTIVE_O(bod_act),
        .WDT_ACTIVE_O(wdt_act), .INPUT_BUF_EN_O(ibuf), .ACMP_ON_O(acmp_on),
        .REF_ON_O(ref_on), .ADC_ON_O(adc_on), .ADC_EXTENDED_O(adc_ext));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic end_sim();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("status read", {24'h0, exp}, {24'h0, rdata});
    endtask
    // counts edges until the core leaves reset; exp <= 0 skips the exact count
    task automatic wait_core(input int exp);
        n = 0;
        while (core_n !== 1'b1 && n < 400) begin
            step(1);
            n++;
        end
        if (n >= 400) begin
            errors++;
            end_sim();
        end
        if (exp > 0) chk("release delay", exp, n);
        chk("vector fetch", 1, {31'h0, vec});
    endtask
    task automatic dip(input int k);
        @(posedge clk);
        bod_cmd <= 1'b1;
        repeat (k) @(posedge clk);
        bod_cmd <= 1'b0;
        step(2);
    endtask
    initial begin
        #400000;
        errors++;
        end_sim();
    end
    initial begin
        errors = 0;
        checked = 0;
        rst_n = 1'b0;
        fuses = '0;
        fuses.clock_select_fuses = CS;
        pm = '0;
        wake = 23'h000005;
        wdt_en = 1'b0;
        {wr, rd, addr, wdata} = '0;
        {por_cmd, pin_cmd, wdt_cmd, bod_cmd} = 4'b1100;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        step(2);
        chk("adc extended", 1, {31'h0, adc_ext});
        @(posedge clk);
        por_cmd <= 1'b0;
        wait_core(REL);
        reg_rd(4'h0, 8'h01);
        reg_rd(4'h5, 8'h00);
        reg_wr(4'h5, 8'h00);
        reg_wr(4'h0, 8'hff);
        reg_rd(4'h0, 8'h01);
        reg_wr(4'h0, 8'h00);
        reg_rd(4'h0, 8'h00);
        @(posedge clk);
        pin_cmd <= 1'b0;
        step(1);
        chk("io reset", 0, {31'h0, io_n});
        @(posedge clk);
        pin_cmd <= 1'b1;
        wait_core(REL);
        reg_rd(4'h0, 8'h02);
        @(posedge clk);
        por_cmd <= 1'b1;
        step(3);
        por_cmd <= 1'b0;
        wait_core(REL);
        reg_rd(4'h0, 8'h01);
        reg_wr(4'h0, 8'h00);
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            wdt_en <= e[0];
            wdt_cmd <= 1'b1;
            @(posedge clk);
            wdt_cmd <= 1'b0;
            n = 0;
            repeat (4) begin
                step(1);
                if (io_n !== 1'b1) n++;
            end
            chk("wdt pulse", e, n);
            if (e != 0) begin
                wait_core(0);
            end else begin
                chk("core kept running", 1, {31'h0, core_n});
            end
            reg_rd(4'h0, e[0] ? 8'h08 : 8'h00);
        end
        reg_wr(4'h0, 8'h00);
        dip(600);
        chk("bod fuse off", 1, {31'h0, core_n});
        fuses.brownout_enable_fuse <= 1'b1;
        dip(450);
        chk("bod short dip", 1, {31'h0, core_n});
        dip(520);
        chk("bod reset", 0, {31'h0, core_n});
        wait_core(0);
        reg_rd(4'h0, 8'h04);
        for (int l = 0; l < 2; l++) begin
            fuses.brownout_level_fuse <= l[0];
            step(1);
            chk("threshold select", l, {31'h0, thr});
        end
        wdt_en <= 1'b1;
        pm.acmp_enable <= 1'b1;
        pm.adc_enable <= 1'b1;
        pm.sleep_active <= 1'b1;
        for (int m = 0; m < 16; m++) begin
            pm.sleep_mode <= rss_sleep_mode_t'(m[2:0]);
            pm.acmp_use_ref <= m[3];
            step(1);
            deep = (m[2:0] == 3'h2) || (m[2:0] == 3'h3) || (m[2:0] == 3'h6);
            chk("input buffers", deep ? wake : 23'h7fffff, ibuf);
            chk("sleep keep", 3'h7, {bod_act, wdt_act, adc_on});
            if (m[2:0] < 3'h4 || m[2:0] == 3'h6)
                chk("comparator", m[3] || m[2:0] < 3'h2, acmp_on);
        end
        pm.sleep_active <= 1'b0;
        for (int c = 0; c < 8; c++) begin
            fuses.brownout_enable_fuse <= c[0];
            pm.acmp_use_ref <= c[1];
            pm.adc_enable <= c[2];
            step(1);
            chk("reference on", c != 0, {31'h0, ref_on});
        end
        pm.adc_conv_start <= 1'b1;
        @(posedge clk);
        pm.adc_conv_start <= 1'b0;
        step(1);
        chk("adc extended", 0, {31'h0, adc_ext});
        pm.adc_enable <= 1'b0;
        step(1);
        pm.adc_enable <= 1'b1;
        step(1);
        chk("adc extended", 1, {31'h0, adc_ext});
        end_sim();
    end
endmodule // testbench

// ===== verilog/rss_top.sv
module rss_top #(
    parameter int STARTUP_BASE_CYCLES = rss_pkg::STARTUP_BASE_CYC,
    parameter int NUM_PINS = 23
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire rss_pkg::rss_fuse_t FUSES_I,
    input wire logic POR_ACTIVE_I,
    input wire logic EXT_RST_N_I,
    input wire logic WDT_ENABLE_I,
    input wire logic WDT_EXPIRE_I,
    input wire logic BOD_LOW_I,
    input wire rss_pkg::rss_pm_req_t PM_REQ_I,
    input wire logic [NUM_PINS-1:0] WAKE_PIN_MASK_I,
    input wire logic [rss_pkg::REG_ADDR_W-1:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    output logic IO_RESET_N_O,
    output logic CORE_RESET_N_O,
    output logic VECTOR_FETCH_O,
    output logic BOD_THRESH_SEL_O,
    output logic BOD_ACTIVE_O,
    output logic WDT_ACTIVE_O,
    output logic [NUM_PINS-1:0] INPUT_BUF_EN_O,
    output logic ACMP_ON_O,
    output logic REF_ON_O,
    output logic ADC_ON_O,
    output logic ADC_EXTENDED_O
);
    import rss_pkg::*;

    typedef enum logic [2:0] {
        ST_HOLD = 3'h1,
        ST_COUNT = 3'h2,
        ST_RUN = 3'h4
    } rss_state_t;

    rss_state_t state_ff;
    rss_state_t nxt_state;
    logic [BOD_CNT_W-1:0] bod_cnt_ff;
    logic [TOUT_CNT_W-1:0] tout_cnt_ff;
    logic [TOUT_CNT_W-1:0] tout_limit;
    logic wdt_exp_q_ff;
    logic wdt_pulse_ff;
    logic fetch_ff;
    logic [3:0] flags_ff;
    logic [3:0] nxt_flags;
    logic [7:0] rdata_ff;
    logic adc_en_q_ff;
    logic adc_ext_ff;
    logic bod_low_q;
    logic bod_rst;
    logic pin_rst;
    logic any_src;
    logic deep_sleep;
    logic flag_wr;

    // brown-out detection qualified by the enable fuse and a persistence filter
    assign bod_low_q = FUSES_I.brownout_enable_fuse & BOD_LOW_I;
    assign bod_rst = bod_low_q && (bod_cnt_ff == BOD_CNT_W'(BOD_MIN_CYC));
    assign pin_rst = ~EXT_RST_N_I;

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bod_cnt_ff <= '0;
        end else if (!bod_low_q) begin
            bod_cnt_ff <= '0;
        end else if (bod_cnt_ff != BOD_CNT_W'(BOD_MIN_CYC)) begin
            bod_cnt_ff <= bod_cnt_ff + 1'b1;
        end
    end

    // watchdog expiry gives a single-cycle pulse, only when enabled
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wdt_exp_q_ff <= 1'b0;
            wdt_pulse_ff <= 1'b0;
        end else begin
            wdt_exp_q_ff <= WDT_EXPIRE_I;
            wdt_pulse_ff <= WDT_ENABLE_I & WDT_EXPIRE_I & ~wdt_exp_q_ff;
        end
    end

    // the four sources merged; por and pin act combinationally on the outputs
    assign any_src = POR_ACTIVE_I | pin_rst | wdt_pulse_ff | bod_rst;
    assign IO_RESET_N_O = ~any_src;
    assign CORE_RESET_N_O = (state_ff == ST_RUN) & ~any_src;
    assign VECTOR_FETCH_O = fetch_ff;

    // start-up time-out length from the clock select fuses
    assign tout_limit = TOUT_CNT_W'(STARTUP_BASE_CYCLES) *
                        (TOUT_CNT_W'(FUSES_I.clock_select_fuses) + 1'b1);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_HOLD: begin
                if (!any_src) begin
                    nxt_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (any_src) begin
                    nxt_state = ST_HOLD;
                end else if (tout_cnt_ff == tout_limit - 1'b1) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (any_src) begin
                    nxt_state = ST_HOLD;
                end
            end
            default: begin
                nxt_state = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff <= ST_HOLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tout_cnt_ff <= '0;
        end else if (state_ff == ST_COUNT && !any_src) begin
            tout_cnt_ff <= tout_cnt_ff + 1'b1;
        end else begin
            tout_cnt_ff <= '0;
        end
    end

    // one-cycle pulse telling the core to fetch from the reset vector
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fetch_ff <= 1'b0;
        end else begin
            fetch_ff <= (state_ff == ST_COUNT) && (nxt_state == ST_RUN);
        end
    end

    // reset cause flags: zero-writes clear, events set and win over the clear
    assign flag_wr = REG_WR_I && (REG_ADDR_I == RESET_CAUSE_OFS);

    always_comb begin
        nxt_flags = flags_ff;
        if (flag_wr) begin
            nxt_flags = flags_ff & REG_WDATA_I[3:0];
        end
        if (wdt_pulse_ff) begin
            nxt_flags[WATCHDOG_FLAG_BIT] = 1'b1;
        end
        if (bod_rst) begin
            nxt_flags[BROWNOUT_FLAG_BIT] = 1'b1;
        end
        if (pin_rst) begin
            nxt_flags[PIN_FLAG_BIT] = 1'b1;
        end
        if (POR_ACTIVE_I) begin
            // power-on clears the other causes and never itself
            nxt_flags = 4'h0;
            nxt_flags[POWERON_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flags_ff <= RESET_CAUSE_RST[3:0];
        end else begin
            flags_ff <= nxt_flags & FLAG_MASK;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_ff <= 8'h00;
        end else if (REG_RD_I && REG_ADDR_I == RESET_CAUSE_OFS) begin
            rdata_ff <= {4'h0, flags_ff};
        end else begin
            rdata_ff <= 8'h00;
        end
    end
    assign REG_RDATA_O = rdata_ff;

    // brown-out threshold select and sleep-independent enables
    assign BOD_THRESH_SEL_O = FUSES_I.brownout_level_fuse;
    assign BOD_ACTIVE_O = FUSES_I.brownout_enable_fuse;
    assign WDT_ACTIVE_O = WDT_ENABLE_I;

    // modes with both I/O and ADC clocks stopped
    assign deep_sleep = PM_REQ_I.sleep_active &&
                        (PM_REQ_I.sleep_mode == SLP_POWER_DOWN ||
                         PM_REQ_I.sleep_mode == SLP_POWER_SAVE ||
                         PM_REQ_I.sleep_mode == SLP_STANDBY);

    for (genvar gi = 0; gi < NUM_PINS; gi++) begin : g_inbuf
        assign INPUT_BUF_EN_O[gi] = ~deep_sleep | WAKE_PIN_MASK_I[gi];
    end

    assign ACMP_ON_O = PM_REQ_I.acmp_enable &&
                       (!PM_REQ_I.sleep_active ||
                        PM_REQ_I.sleep_mode == SLP_IDLE ||
                        PM_REQ_I.sleep_mode == SLP_ADC_NR ||
                        PM_REQ_I.acmp_use_ref);
    assign REF_ON_O = FUSES_I.brownout_enable_fuse |
                      (ACMP_ON_O & PM_REQ_I.acmp_use_ref) |
                      PM_REQ_I.adc_enable;
    assign ADC_ON_O = PM_REQ_I.adc_enable;

    // extended-conversion marker armed by an ADC off, dropped at next start
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            adc_en_q_ff <= 1'b0;
            adc_ext_ff <= 1'b1;
        end else begin
            adc_en_q_ff <= PM_REQ_I.adc_enable;
            if (adc_en_q_ff && !PM_REQ_I.adc_enable) begin
                adc_ext_ff <= 1'b1;
            end else if (PM_REQ_I.adc_enable && PM_REQ_I.adc_conv_start) begin
                adc_ext_ff <= 1'b0;
            end
        end
    end
    assign ADC_EXTENDED_O = adc_ext_ff;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_io_async_rst: assert property (any_src |-> !IO_RESET_N_O)
        else $error("io reset not asserted with active source");
    a_pin_core_rst: assert property (pin_rst |-> !CORE_RESET_N_O && !IO_RESET_N_O)
        else $error("pin low did not hold reset");
    a_por_instant: assert property (POR_ACTIVE_I |-> !CORE_RESET_N_O ##1 flags_ff == 4'h1)
        else $error("power-on did not reset and mark cause");
    a_delay_stretch: assert property ($fell(any_src) |-> !CORE_RESET_N_O [*8])
        else $error("core reset released without delay");
    a_delay_end: assert property (state_ff == ST_COUNT && !any_src &&
        tout_cnt_ff == tout_limit - 1'b1 ##1 !any_src |-> CORE_RESET_N_O)
        else $error("core reset not released at time-out");
    a_release_fetch: assert property ($rose(CORE_RESET_N_O) |-> VECTOR_FETCH_O)
        else $error("no vector fetch at release");
    a_four_sources: assert property (CORE_RESET_N_O |-> !POR_ACTIVE_I && EXT_RST_N_I &&
        !wdt_pulse_ff && !bod_rst)
        else $error("core running with active source");
    a_bod_fuse_off: assert property (!FUSES_I.brownout_enable_fuse |-> !bod_rst)
        else $error("brown-out reset with fuse unprogrammed");
    a_bod_filter: assert property ($rose(bod_low_q) |-> !bod_rst [*8])
        else $error("short brown-out dip caused reset");
    a_bod_recog: assert property (bod_low_q && bod_cnt_ff == BOD_CNT_W'(BOD_MIN_CYC - 1)
        ##1 bod_low_q |-> !IO_RESET_N_O ##1 flags_ff[BROWNOUT_FLAG_BIT])
        else $error("persistent brown-out not recognised");
    a_bod_release: assert property ($fell(bod_low_q) && !POR_ACTIVE_I && !pin_rst &&
        !wdt_pulse_ff |-> IO_RESET_N_O)
        else $error("brown-out release did not free sources");
    a_bod_level: assert property (BOD_THRESH_SEL_O == FUSES_I.brownout_level_fuse)
        else $error("threshold select wrong");
    a_wdt_gate: assert property (wdt_pulse_ff |-> $past(WDT_ENABLE_I))
        else $error("watchdog reset while disabled");
    a_wdt_pulse: assert property (wdt_pulse_ff |=> !wdt_pulse_ff)
        else $error("watchdog pulse longer than one cycle");
    a_wdt_flag: assert property (wdt_pulse_ff && !POR_ACTIVE_I |=>
        flags_ff[WATCHDOG_FLAG_BIT])
        else $error("watchdog flag not set");
    a_pin_flag: assert property (pin_rst && !POR_ACTIVE_I |=> flags_ff[PIN_FLAG_BIT])
        else $error("pin flag not set");
    a_por_flag_hold: assert property (flags_ff[POWERON_FLAG_BIT] && !flag_wr |=>
        flags_ff[POWERON_FLAG_BIT])
        else $error("power-on flag lost without write");
    a_rsvd_read: assert property (REG_RD_I && REG_ADDR_I == RESET_CAUSE_OFS |=>
        REG_RDATA_O == {4'h0, $past(flags_ff)})
        else $error("status read wrong");
    a_write_one: assert property (flag_wr && !any_src |=>
        flags_ff == ($past(flags_ff) & $past(REG_WDATA_I[3:0])))
        else $error("status write misbehaved");
    a_sleep_keep: assert property (BOD_ACTIVE_O == FUSES_I.brownout_enable_fuse &&
        WDT_ACTIVE_O == WDT_ENABLE_I)
        else $error("monitor gated by sleep");
    a_inbuf_off: assert property (deep_sleep |-> INPUT_BUF_EN_O == WAKE_PIN_MASK_I)
        else $error("input buffers not gated");
    a_acmp_off: assert property (deep_sleep && !PM_REQ_I.acmp_use_ref |-> !ACMP_ON_O)
        else $error("comparator not disabled in sleep");
    a_ref_or: assert property (REF_ON_O == (FUSES_I.brownout_enable_fuse |
        (ACMP_ON_O & PM_REQ_I.acmp_use_ref) | PM_REQ_I.adc_enable))
        else $error("reference enable wrong");
    a_adc_ext: assert property ($fell(PM_REQ_I.adc_enable) |=> ADC_EXTENDED_O)
        else $error("extended conversion not armed");

    c_por_release: cover property ($fell(POR_ACTIVE_I) ##[1:1000] $rose(CORE_RESET_N_O));
    c_wdt_reset: cover property (CORE_RESET_N_O ##1 wdt_pulse_ff);
    c_bod_reset: cover property ($rose(bod_rst));
    c_sw_clear: cover property (flag_wr && flags_ff != 4'h0 ##1 flags_ff == 4'h0);

endmodule // rss_top
